/* rtl/vicr_pkg.sv */
// Purpose: shared constants for the vbi interrupt and config ram register block
// Assumes: 8-bit register port, one register per subaddress
// Notes: offsets, field positions and the mask, pin, ram address and data reset values live here; other registers reset to literal zero
package vicr_pkg;
    // register subaddresses
    localparam logic [7:0] ADDR_STATUS_A = 8'hc0;
    localparam logic [7:0] ADDR_MASK_A = 8'hc1;
    localparam logic [7:0] ADDR_PIN_CFG_A = 8'hc2;
    localparam logic [7:0] ADDR_RAM_DATA = 8'hc3;
    localparam logic [7:0] ADDR_RAM_LOW = 8'hc4;
    localparam logic [7:0] ADDR_RAM_HIGH = 8'hc5;
    localparam logic [7:0] ADDR_SLICER_STATUS = 8'hc6;

    // interrupt status / enable bit positions
    localparam int IRQ_LOCK_STATE_BIT = 7;
    localparam int IRQ_LOCK_BIT = 6;
    localparam int IRQ_CYCLE_DONE_BIT = 5;
    localparam int IRQ_BUS_ERROR_BIT = 4;
    localparam int IRQ_FIFO_THRESH_BIT = 2;
    localparam int IRQ_LINE_BIT = 1;
    localparam int IRQ_DATA_BIT = 0;
    localparam logic [7:0] MASK_A_WRITABLE = 8'h77;
    localparam logic [7:0] STATUS_A_VALID = 8'hf7;
    localparam logic [7:0] MASK_A_RESET = 8'h00;

    // interrupt pin configuration fields
    localparam int PIN_POLARITY_BIT = 0;
    localparam int PIN_IRQ_ACTIVE_BIT = 1;
    localparam int PIN_PIXEL_ENABLE_BIT = 2;
    localparam logic PIN_POLARITY_RESET = 1'b0;
    localparam logic PIN_PIXEL_ENABLE_RESET = 1'b1;

    // slicer status fields
    localparam int SLC_FULL_ERROR_BIT = 7;
    localparam int SLC_FIFO_EMPTY_BIT = 6;
    localparam int SLC_TELETEXT_BIT = 5;
    localparam int SLC_CC_FIELD1_BIT = 4;
    localparam int SLC_CC_FIELD2_BIT = 3;
    localparam int SLC_WSS_BIT = 2;
    localparam int SLC_VPS_BIT = 1;
    localparam int SLC_VITC_BIT = 0;
    localparam logic [7:0] SLC_STICKY = 8'hbf;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // configuration ram geometry
    localparam int RAM_SLOTS = 32;
    localparam int RAM_SLOT_BYTES = 16;
    localparam int RAM_BYTES = RAM_SLOTS * RAM_SLOT_BYTES;
    localparam int RAM_AW = $clog2(RAM_BYTES);
    localparam logic [RAM_AW-1:0] RAM_ADDR_RESET = 9'h000;
    localparam logic [RAM_AW-1:0] RAM_CUSTOM_SLOT_0 = 9'h1a0;
    localparam logic [RAM_AW-1:0] RAM_CUSTOM_SLOT_1 = 9'h1b0;
    localparam logic [7:0] DATA_RESET = 8'h00;
endpackage

/* rtl/vicr_cfg_ram_if.sv */
// Purpose: carrier between the register logic and the configuration ram
// Assumes: single clock, one access per cycle
// Notes: read data is combinational from the addressed byte
`timescale 1ns/100ps
interface vicr_cfg_ram_if #(
    parameter int AW = 9
);
    logic wr_en;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output wr_en, output addr, output wdata, input rdata);
    modport mem (input wr_en, input addr, input wdata, output rdata);
endinterface

/* rtl/vicr_cfg_ram.sv */
// Purpose: slicer configuration ram held in flip-flops
// Assumes: byte wide, addressed by index
// Notes: contents are not reset, the host loads them before use
`timescale 1ns/100ps
module vicr_cfg_ram #(
    parameter int DEPTH = vicr_pkg::RAM_BYTES,
    parameter int AW = vicr_pkg::RAM_AW
) (
    input wire logic clk_sys_in,
    input wire logic ce_in,
    vicr_cfg_ram_if.mem ram
);
    logic [7:0] mem_reg [DEPTH];

    always_ff @(posedge clk_sys_in) begin
        if (ce_in && ram.wr_en) begin
            mem_reg[ram.addr] <= ram.wdata; // [RULE_09]
        end
    end

    assign ram.rdata = mem_reg[ram.addr];
endmodule

/* rtl/vicr_sticky_flags.sv */
// Purpose: write-one-to-clear sticky flag bank
// Assumes: set and clear pulses on the same clock
// Notes: a set in the clear cycle wins, so no event is lost
`timescale 1ns/100ps
module vicr_sticky_flags #(
    parameter int WIDTH = 8
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clear_in,
    output logic [WIDTH-1:0] flags_out
);
    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    always_comb begin
        flags_next = (flags_reg & ~clear_in) | set_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            flags_reg <= '0;
        end else if (ce_in) begin
            flags_reg <= flags_next;
        end
    end

    assign flags_out = flags_reg;
endmodule

/* rtl/vicr_top.sv */
// Purpose: interrupt mask, pin config, config ram access and slicer status
// Assumes: host register strobes and event inputs come from logic on clk_sys_in
// Notes: read data appears one cycle after the read strobe
//
// Summary of operation
// (RULE_01) enable bit one lets its status condition drive the interrupt pin
// (RULE_02) mask gates only the pin; status bits set regardless of enable
// (RULE_03) enables: lock 6, cycle 5, bus error 4, threshold 2, line 1, data 0
// (RULE_04) config bit 1 reads one while interrupt is active on the pin
// (RULE_05) config bit 0 picks pin sense: zero active low, one active high
// (RULE_06) active low: pull pin low when active, release otherwise
// (RULE_07) active high: drive pin high when active, low otherwise
// (RULE_08) config bit 2 enables pixel output bus; resets to enabled
// (RULE_09) configuration ram of 512 bytes as 32 slots of 16 bytes
// (RULE_10) each data port access uses the address counter then advances it
// (RULE_11) counter loads 9 bits: high register bit 0, low register bits 7..0
// (RULE_12) host sets all line mode registers to ff before ram access
// (RULE_13) host turns full field slicing off before ram access
// (RULE_14) first twelve slots predefined; two custom slots at 1a0 and 1b0
// (RULE_15) reading never clears slicer flags; writing one clears that flag
// (RULE_16) fifo empty flag follows live fifo state without host clearing
// (RULE_17) slicer bits: full 7, empty 6, teletext 5, cc 4 3, wss vps vitc
// (RULE_18) line not fitting fifo sets full error and is dropped whole
// (RULE_19) later lines that fit are still written while full error stands
// (RULE_20) status a bits clear by writing one; positions match the enables
// (RULE_21) ram address counter wraps from 511 to zero
`timescale 1ns/100ps
module vicr_top #(
    parameter int LEN_W = 8,
    parameter int SPACE_W = 10
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic [7:0] status_a_event_in,
    input wire logic [7:0] slicer_event_in,
    input wire logic fifo_empty_in,
    input wire logic line_req_in,
    input wire logic [LEN_W-1:0] line_bytes_in,
    input wire logic [SPACE_W-1:0] fifo_space_in,
    output logic line_write_out,
    output logic line_drop_out,
    output logic irq_out,
    output logic irq_oe_out,
    output logic pixel_output_pin_enable_out
);
    localparam int AW = vicr_pkg::RAM_AW;

    logic [7:0] mask_a_reg;
    logic polarity_reg;
    logic pixel_enable_reg;
    logic irq_active_reg;
    logic [AW-1:0] ram_addr_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic line_write_reg;
    logic line_drop_reg;
    logic fifo_empty_reg;

    logic [7:0] status_a;
    logic [7:0] slicer_flags;
    logic [7:0] status_a_set;
    logic [7:0] status_a_clear;
    logic [7:0] slicer_set;
    logic [7:0] slicer_clear;
    logic [7:0] slicer_view;
    logic [7:0] read_mux;
    logic irq_active_next;
    logic ram_access;
    logic line_fits;
    logic line_drop_now;
    logic wr_hit;

    vicr_cfg_ram_if #(.AW(AW)) ram_bus ();

    vicr_cfg_ram #(
        .DEPTH(vicr_pkg::RAM_BYTES),
        .AW(AW)
    ) u_cfg_ram (
        .clk_sys_in(clk_sys_in),
        .ce_in(ce_in),
        .ram(ram_bus)
    );

    // status a: hardware sets, host writes one to clear
    vicr_sticky_flags #(.WIDTH(8)) u_status_a (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .set_in(status_a_set),
        .clear_in(status_a_clear),
        .flags_out(status_a)
    );

    vicr_sticky_flags #(.WIDTH(8)) u_slicer_flags (
        .clk_sys_in(clk_sys_in),
        .nrst_in(nrst_in),
        .ce_in(ce_in),
        .set_in(slicer_set),
        .clear_in(slicer_clear),
        .flags_out(slicer_flags)
    );

    assign wr_hit = reg_wr_in;

    // status set ignores the mask entirely
    assign status_a_set = status_a_event_in & vicr_pkg::STATUS_A_VALID; // [RULE_02]
    assign status_a_clear = (wr_hit && reg_addr_in == vicr_pkg::ADDR_STATUS_A) ?
        (reg_wdata_in & vicr_pkg::STATUS_A_VALID) : 8'h00; // [RULE_20]

    // line admission: whole line or nothing
    // both sides widened to one width so neither count is cut
    localparam int CMP_W = (LEN_W > SPACE_W) ? LEN_W : SPACE_W;
    logic [CMP_W-1:0] bytes_cmp;
    logic [CMP_W-1:0] space_cmp;
    assign bytes_cmp = CMP_W'(line_bytes_in);
    assign space_cmp = CMP_W'(fifo_space_in);
    assign line_fits = bytes_cmp <= space_cmp;
    assign line_drop_now = line_req_in && !line_fits; // [RULE_18]

    always_comb begin
        slicer_set = slicer_event_in & vicr_pkg::SLC_STICKY;
        slicer_set[vicr_pkg::SLC_FULL_ERROR_BIT] = line_drop_now; // [RULE_18]
    end

    // a read never clears; only written ones do
    assign slicer_clear = (wr_hit && reg_addr_in == vicr_pkg::ADDR_SLICER_STATUS) ?
        (reg_wdata_in & vicr_pkg::SLC_STICKY) : 8'h00; // [RULE_15]

    always_comb begin
        slicer_view = slicer_flags;
        slicer_view[vicr_pkg::SLC_FIFO_EMPTY_BIT] = fifo_empty_reg; // [RULE_16] [RULE_17]
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            fifo_empty_reg <= 1'b0;
        end else if (ce_in) begin
            fifo_empty_reg <= fifo_empty_in; // [RULE_16]
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            line_write_reg <= 1'b0;
            line_drop_reg <= 1'b0;
        end else if (ce_in) begin
            // full error does not block later lines that fit
            line_write_reg <= line_req_in && line_fits; // [RULE_19]
            line_drop_reg <= line_drop_now; // [RULE_18]
        end
    end

    // interrupt enable mask
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            mask_a_reg <= vicr_pkg::MASK_A_RESET; // [RULE_03]
        end else if (ce_in && wr_hit && reg_addr_in == vicr_pkg::ADDR_MASK_A) begin
            mask_a_reg <= reg_wdata_in & vicr_pkg::MASK_A_WRITABLE; // [RULE_03]
        end
    end

    // pin configuration
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            polarity_reg <= vicr_pkg::PIN_POLARITY_RESET; // [RULE_05]
            pixel_enable_reg <= vicr_pkg::PIN_PIXEL_ENABLE_RESET; // [RULE_08]
        end else if (ce_in && wr_hit && reg_addr_in == vicr_pkg::ADDR_PIN_CFG_A) begin
            polarity_reg <= reg_wdata_in[vicr_pkg::PIN_POLARITY_BIT]; // [RULE_05]
            pixel_enable_reg <= reg_wdata_in[vicr_pkg::PIN_PIXEL_ENABLE_BIT]; // [RULE_08]
        end
    end

    // pin level registered so the readback bit matches the pin exactly
    assign irq_active_next = |(status_a & mask_a_reg); // [RULE_01]

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            irq_active_reg <= 1'b0;
        end else if (ce_in) begin
            irq_active_reg <= irq_active_next; // [RULE_01]
        end
    end

    always_comb begin
        if (polarity_reg) begin
            irq_out = irq_active_reg; // [RULE_07]
            irq_oe_out = 1'b1; // [RULE_07]
        end else begin
            // open collector: drive only the low level
            irq_out = 1'b0; // [RULE_06]
            irq_oe_out = irq_active_reg; // [RULE_06]
        end
    end

    assign pixel_output_pin_enable_out = pixel_enable_reg; // [RULE_08]

    // ram address counter; a read and write together advance it once
    assign ram_access = (reg_wr_in || reg_rd_in) && reg_addr_in == vicr_pkg::ADDR_RAM_DATA;

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            ram_addr_reg <= vicr_pkg::RAM_ADDR_RESET;
        end else if (ce_in) begin
            if (wr_hit && reg_addr_in == vicr_pkg::ADDR_RAM_LOW) begin
                ram_addr_reg[7:0] <= reg_wdata_in; // [RULE_11]
            end else if (wr_hit && reg_addr_in == vicr_pkg::ADDR_RAM_HIGH) begin
                ram_addr_reg[AW-1] <= reg_wdata_in[0]; // [RULE_11]
            end else if (ram_access) begin
                // natural 9-bit rollover gives the wrap
                ram_addr_reg <= ram_addr_reg + AW'(1); // [RULE_10] [RULE_21]
            end
        end
    end

    assign ram_bus.addr = ram_addr_reg; // [RULE_10]
    assign ram_bus.wr_en = wr_hit && reg_addr_in == vicr_pkg::ADDR_RAM_DATA; // [RULE_10]
    assign ram_bus.wdata = reg_wdata_in;

    // register read mux; unmapped subaddresses read zero
    always_comb begin
        case (reg_addr_in)
            vicr_pkg::ADDR_STATUS_A: read_mux = status_a; // [RULE_20]
            vicr_pkg::ADDR_MASK_A: read_mux = mask_a_reg;
            vicr_pkg::ADDR_PIN_CFG_A: begin
                read_mux = 8'h00;
                read_mux[vicr_pkg::PIN_POLARITY_BIT] = polarity_reg;
                read_mux[vicr_pkg::PIN_IRQ_ACTIVE_BIT] = irq_active_reg; // [RULE_04]
                read_mux[vicr_pkg::PIN_PIXEL_ENABLE_BIT] = pixel_enable_reg;
            end
            vicr_pkg::ADDR_RAM_DATA: read_mux = ram_bus.rdata; // [RULE_10]
            vicr_pkg::ADDR_RAM_LOW: read_mux = ram_addr_reg[7:0];
            vicr_pkg::ADDR_RAM_HIGH: read_mux = {7'h00, ram_addr_reg[AW-1]};
            vicr_pkg::ADDR_SLICER_STATUS: read_mux = slicer_view; // [RULE_17]
            default: read_mux = vicr_pkg::DATA_RESET;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            rdata_reg <= vicr_pkg::DATA_RESET;
            rvalid_reg <= 1'b0;
        end else if (ce_in) begin
            rvalid_reg <= reg_rd_in;
            if (reg_rd_in) begin
                rdata_reg <= read_mux;
            end
        end
    end

    assign reg_rdata_out = rdata_reg;
    assign reg_rvalid_out = rvalid_reg;
    assign line_write_out = line_write_reg;
    assign line_drop_out = line_drop_reg;
endmodule

/* test/vicr_top_monitor.sv */
// Purpose: port checks for the interrupt and config ram register block
// Assumes: one clock, ce_in held high by the bench except during one status pulse
// Notes: mask and polarity are mirrored from host writes
`timescale 1ns/100ps
module vicr_top_monitor #(
    parameter int LEN_W = 8,
    parameter int SPACE_W = 10
) (
    input wire logic clk_sys_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic [7:0] status_a_event_in,
    input wire logic [7:0] slicer_event_in,
    input wire logic fifo_empty_in,
    input wire logic line_req_in,
    input wire logic [LEN_W-1:0] line_bytes_in,
    input wire logic [SPACE_W-1:0] fifo_space_in,
    input wire logic line_write_out,
    input wire logic line_drop_out,
    input wire logic irq_out,
    input wire logic irq_oe_out,
    input wire logic pixel_output_pin_enable_out
);
    logic [7:0] mask_m;
    logic pol_m;
    logic act;
    logic rd_ok;
    // pin level seen as active, whichever sense is chosen
    assign act = pol_m ? irq_out : irq_oe_out;
    assign rd_ok = reg_rd_in && ce_in;
    always_ff @(posedge clk_sys_in) begin
        if (!nrst_in) begin
            mask_m <= 8'h00;
            pol_m <= 1'b0;
        end else if (ce_in && reg_wr_in && reg_addr_in == vicr_pkg::ADDR_MASK_A) begin
            mask_m <= reg_wdata_in & vicr_pkg::MASK_A_WRITABLE;
        end else if (ce_in && reg_wr_in && reg_addr_in == vicr_pkg::ADDR_PIN_CFG_A) begin
            pol_m <= reg_wdata_in[0];
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!nrst_in);
    AST_RVALID: assert property (ce_in |=> reg_rvalid_out == $past(reg_rd_in))
        else $error("read valid pulse wrong");
    AST_DROP: assert property (line_req_in && ce_in && line_bytes_in > fifo_space_in
        |=> line_drop_out && !line_write_out)
        else $error("oversize line not dropped");
    AST_FIT: assert property (line_req_in && ce_in && line_bytes_in <= fifo_space_in
        |=> line_write_out && !line_drop_out)
        else $error("fitting line not written");
    AST_NO_REQ: assert property (!line_req_in && ce_in
        |=> !line_write_out && !line_drop_out)
        else $error("line pulse without request");
    AST_RELEASED: assert property (!irq_oe_out |-> !irq_out)
        else $error("released pin carries a high level");
    AST_HIGH: assert property (pol_m && $past(pol_m) |-> irq_oe_out)
        else $error("active high pin not driven");
    AST_MASKED: assert property (mask_m == 8'h00 ##1 $stable(pol_m)
        |-> !act)
        else $error("masked condition reached the pin");
    AST_CFG_RD: assert property (rd_ok
        && reg_addr_in == vicr_pkg::ADDR_PIN_CFG_A |=> reg_rdata_out ==
        {5'h00, $past(pixel_output_pin_enable_out), $past(act), $past(pol_m)})
        else $error("pin config readback wrong");
    AST_MASK_RD: assert property (rd_ok && reg_addr_in == vicr_pkg::ADDR_MASK_A
        |=> reg_rdata_out == $past(mask_m))
        else $error("mask readback wrong");
    AST_EMPTY: assert property (rd_ok && reg_addr_in == vicr_pkg::ADDR_SLICER_STATUS
        |=> reg_rdata_out[6] == $past(fifo_empty_in, 2))
        else $error("empty flag does not follow fifo");
    AST_PIX_RST: assert property ($rose(nrst_in) |-> pixel_output_pin_enable_out)
        else $error("pixel enable not set by reset");
endmodule

/* test/vicr_host_model.sv */
// Purpose: host on the register port, one strobe per access
// Assumes: driven at the falling edge, read data one cycle later
// Notes: released lines show the inverse so stale values never match
`timescale 1ns/100ps
module vicr_host_model (
    input wire logic clk_sys_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [7:0] reg_wdata_out,
    input wire logic [7:0] reg_rdata_in,
    input wire logic reg_rvalid_in
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_wdata_out = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_out = a;
        reg_wdata_out = d;
        reg_wr_out = 1'b1;
        @(negedge clk_sys_in);
        reg_wr_out = 1'b0;
        reg_addr_out = ~a;
        reg_wdata_out = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_sys_in);
        reg_addr_out = a;
        reg_rd_out = 1'b1;
        @(negedge clk_sys_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        d = reg_rvalid_in ? reg_rdata_in : 8'hxx;
    endtask
    // line modes to ff and full field off before any ram access
    task automatic prep();
        logic [7:0] a;
        for (a = 8'hd0; a <= 8'hfb; a++) wr(a, 8'hff);
        wr(8'hcf, 8'h00);
    endtask
endmodule

/* test/vicr_top_bench.sv */
// Purpose: self-checking bench for the interrupt and config ram block
// Assumes: ce_in held high except during one status pulse, host model drives the register port
// Notes: random values from a fixed lfsr seed
`timescale 1ns/100ps
module vicr_top_bench;
    logic clk_sys_in, nrst_in, ce_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
    logic fifo_empty_in, line_req_in, line_write_out, line_drop_out;
    logic irq_out, irq_oe_out, pixel_output_pin_enable_out;
    logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, status_a_event_in;
    logic [7:0] slicer_event_in, line_bytes_in, a, m;
    logic [9:0] fifo_space_in;
    logic [7:0] mem [0:31];
    logic [31:0] seed = 32'hf328;
    int error_cnt = 0;
    int checked = 0;
    int i;
    vicr_top #(.LEN_W(8), .SPACE_W(10)) DUT (.*);
    vicr_host_model host (.clk_sys_in(clk_sys_in), .reg_addr_out(reg_addr_in),
        .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in), .reg_wdata_out(reg_wdata_in),
        .reg_rdata_in(reg_rdata_out), .reg_rvalid_in(reg_rvalid_out));
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    function automatic logic [7:0] exp_line(input logic [7:0] n, input logic [9:0] sp);
        return ({2'b00, n} <= sp) ? 8'h02 : 8'h01;
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] ad, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(ad, d);
        chk(d, exp);
    endtask
    task automatic pulse(input logic [7:0] sa, input logic [7:0] sl);
        @(negedge clk_sys_in);
        status_a_event_in = sa;
        slicer_event_in = sl;
        @(negedge clk_sys_in);
        status_a_event_in = 8'h00;
        slicer_event_in = 8'h00;
    endtask
    // pins settle within two cycles of a write, three leaves margin
    task automatic pins(input logic [7:0] exp);
        repeat (3) @(negedge clk_sys_in);
        chk({6'h00, irq_oe_out, irq_out}, exp);
    endtask
    task automatic line(input logic [7:0] n, input logic [9:0] sp);
        @(negedge clk_sys_in);
        line_req_in = 1'b1;
        line_bytes_in = n;
        fifo_space_in = sp;
        @(negedge clk_sys_in);
        line_req_in = 1'b0;
        chk({6'h00, line_write_out, line_drop_out}, exp_line(n, sp));
    endtask
    task automatic stop_test();
        $display("counts: checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #100000;
        error_cnt++;
        stop_test();
    end
    initial begin
        ce_in = 1'b1;
        nrst_in = 1'b0;
        status_a_event_in = 8'h00;
        slicer_event_in = 8'h00;
        fifo_empty_in = 1'b1;
        line_req_in = 1'b0;
        line_bytes_in = 8'h00;
        fifo_space_in = 10'h000;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        nrst_in = 1'b1;
        rdchk(8'hc1, 8'h00);
        rdchk(8'hc2, 8'h04);
        rdchk(8'hc6, 8'h40);
        rdchk(8'h10, 8'h00);
        // clock enable low must freeze the status bank
        ce_in = 1'b0;
        pulse(8'h02, 8'h00);
        ce_in = 1'b1;
        rdchk(8'hc0, 8'h00);
        $display("test reset done");
        pulse(8'h01, 8'h00);
        rdchk(8'hc0, 8'h01);
        rdchk(8'hc2, 8'h04);
        host.wr(8'hc1, 8'hff);
        rdchk(8'hc1, 8'h77);
        rdchk(8'hc2, 8'h06);
        pins(8'h02);
        host.wr(8'hc2, 8'h05);
        pins(8'h03);
        host.wr(8'hc0, 8'hff);
        pins(8'h02);
        rdchk(8'hc0, 8'h00);
        host.wr(8'hc2, 8'h00);
        pins(8'h00);
        chk({7'h00, pixel_output_pin_enable_out}, 8'h00);
        host.wr(8'hc2, 8'h04);
        for (i = 0; i < 8; i++) begin
            a = rnd();
            m = rnd();
            pulse(a, 8'h00);
            rdchk(8'hc0, a & 8'hf7);
            host.wr(8'hc1, m);
            rdchk(8'hc2, {5'h00, 1'b1, |(a & m & 8'h77), 1'b0});
            host.wr(8'hc0, a);
        end
        $display("test interrupt done");
        host.prep();
        host.wr(8'hc4, 8'ha0);
        host.wr(8'hc5, 8'h01);
        for (i = 0; i < 32; i++) begin
            mem[i] = rnd();
            host.wr(8'hc3, mem[i]);
        end
        rdchk(8'hc4, 8'hc0);
        rdchk(8'hc5, 8'h01);
        host.wr(8'hc4, 8'ha0);
        for (i = 0; i < 32; i++) rdchk(8'hc3, mem[i]);
        host.wr(8'hc4, 8'hff);
        host.wr(8'hc3, 8'h5a);
        host.wr(8'hc3, 8'ha5);
        rdchk(8'hc5, 8'h00);
        rdchk(8'hc4, 8'h01);
        host.wr(8'hc5, 8'h01);
        host.wr(8'hc4, 8'hff);
        rdchk(8'hc3, 8'h5a);
        rdchk(8'hc3, 8'ha5);
        $display("test ram done");
        a = rnd();
        fifo_empty_in = 1'b0;
        pulse(8'h00, a);
        rdchk(8'hc6, a & 8'h3f);
        rdchk(8'hc6, a & 8'h3f);
        host.wr(8'hc6, 8'h4f);
        rdchk(8'hc6, a & 8'h30);
        $display("test slicer flags done");
        line(8'd40, 10'd10);
        rdchk(8'hc6, 8'h80 | (a & 8'h30));
        line(8'd3, 10'd10);
        line(8'd10, 10'd10);
        line(8'd11, 10'd10);
        for (i = 0; i < 8; i++) line(rnd(), {2'b00, rnd()});
        $display("test line admission done");
        stop_test();
    end
endmodule
bind vicr_top vicr_top_monitor #(.LEN_W(LEN_W), .SPACE_W(SPACE_W)) mon (.*);
